// *** inc/sas_pkg.sv ***
// Purpose: Shared constants and types for the successive-approximation sequencer
// Assumes: 8-bit byte-wide CPU register port, 20 MHz main clock
// Notes:   Offsets are byte addresses on the CPU data space
package sas_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CONV_MODE = 16'hff80;
  localparam logic [15:0] ADDR_CHAN_SEL = 16'hff81;
  localparam logic [15:0] ADDR_CONV_RESULT = 16'hff82;

  localparam logic [7:0] CONV_MODE_RESET = 8'h00;
  localparam logic [7:0] CHAN_SEL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int RUN_CONTROL_POS = 7;
  localparam int TRIGGER_SOURCE_POS = 6;
  localparam int CONV_TIME_LSB = 3;
  localparam int TRIGGER_EDGE_LSB = 1;
  localparam int REFERENCE_ENABLE_POS = 0;
  localparam int CHAN_CODE_W = 3;

  typedef struct packed {
    logic runControlBit;
    logic triggerSourceBit;
    logic [2:0] convTime;
    logic [1:0] triggerEdge;
    logic referenceEnableBit;
  } sas_mode_t;

  // ----------------------------------------------------------------
  // Conversion time codes and lengths in main-clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] CT_144 = 3'h0;
  localparam logic [2:0] CT_120 = 3'h1;
  localparam logic [2:0] CT_96 = 3'h2;
  localparam logic [2:0] CT_288 = 3'h4;
  localparam logic [2:0] CT_240 = 3'h5;
  localparam logic [2:0] CT_192 = 3'h6;

  localparam int CONV_CYCLES_144 = 144;
  localparam int CONV_CYCLES_120 = 120;
  localparam int CONV_CYCLES_96 = 96;
  localparam int CONV_CYCLES_288 = 288;
  localparam int CONV_CYCLES_240 = 240;
  localparam int CONV_CYCLES_192 = 192;

  // Total split: sampling takes SAMPLE_SLOTS slots, each bit one slot
  localparam int RES_BITS = 8;
  localparam int SAMPLE_SLOTS = 4;
  localparam int TOTAL_SLOTS = RES_BITS + SAMPLE_SLOTS;
  localparam int PHASE_W = 8;

  // Trigger edge codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // CPU access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic wrEn;
    logic bitOp;
    logic [2:0] bitSel;
    logic bitVal;
    logic [7:0] wrData;
    logic rdEn;
  } sas_cpu_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_TRIG = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONVERT = 4'b1000
  } sas_state_t;

endpackage

// *** core/sas_trig_edge.sv ***
// Purpose: Synchronise the external trigger pin and detect the selected edge
// Assumes: Pin is asynchronous to clk
// Notes:   Pulse output is one cycle, three cycles after the pin moves
`timescale 1ns/1ps
module sas_trig_edge (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pinIn,
  input wire logic [1:0] edgeSel,
  output logic edgePulse
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [1:0] warm_r;
  logic warmed;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // No edge until the history holds real pin levels, so an idle-high pin gives no false edge after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  assign warmed = (warm_r == 2'h3);
  assign rise = warmed & sync2_r & ~prev_r;
  assign fall = warmed & ~sync2_r & prev_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edgePulse <= 1'b0;
    end else begin
      unique case (edgeSel)
        sas_pkg::EDGE_NONE: edgePulse <= 1'b0;
        sas_pkg::EDGE_FALL: edgePulse <= fall;
        sas_pkg::EDGE_RISE: edgePulse <= rise;
        sas_pkg::EDGE_BOTH: edgePulse <= rise | fall;
      endcase
    end
  end

endmodule

// *** core/sas_core.sv ***
// Purpose: Sequencer for an 8-channel 8-bit successive-approximation converter
// Assumes: Byte-wide CPU port with bit writes; comparator and trigger are async pins
// Notes:   Analog front end lives outside; this block drives tap code and sampling
//
// Functional notes
// - Mode register resets zero, byte and bit writes
// - Run bit set repeats conversions until cleared
// - Trigger source bit selects software or hardware
// - Time field sets conversion length in cycles
// - Edge field picks none, falling, rising, both
// - Reference runs when enabled or when running
// - First result after cold start flagged undefined
// - Channel register low three bits, upper zero
// - Sample selected channel, then hold until done
// - Trial from bit seven down to bit zero
// - Keep bit if input at or above tap
// - Copy to result and raise done together
// - Register write aborts, restarts when running
// - Result register has no reset value
// - Start by trigger edge or mode write
// - Hardware mode one shot, software mode repeats
// - Triggers ignored while conversion in progress
// - Writing run bit zero stops immediately
`timescale 1ns/1ps
module sas_core #(
  parameter int RES_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire sas_pkg::sas_cpu_req_t cpuReq,
  output logic [7:0] rdData,
  input wire logic compIn,
  input wire logic extTrigIn,
  output logic [RES_W-1:0] tapCode,
  output logic [sas_pkg::CHAN_CODE_W-1:0] chanSel,
  output logic sampleEn,
  output logic refOn,
  output logic convDoneReq,
  output logic resultUndef
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [sas_pkg::PHASE_W-1:0] slotLen(input logic [2:0] code);
    int cyc;
    begin
      unique case (code)
        sas_pkg::CT_120: cyc = sas_pkg::CONV_CYCLES_120;
        sas_pkg::CT_96: cyc = sas_pkg::CONV_CYCLES_96;
        sas_pkg::CT_288: cyc = sas_pkg::CONV_CYCLES_288;
        sas_pkg::CT_240: cyc = sas_pkg::CONV_CYCLES_240;
        sas_pkg::CT_192: cyc = sas_pkg::CONV_CYCLES_192;
        // Prohibited codes fall back to the 144-cycle default
        default: cyc = sas_pkg::CONV_CYCLES_144;
      endcase
      slotLen = sas_pkg::PHASE_W'(cyc / sas_pkg::TOTAL_SLOTS);
    end
  endfunction

  function automatic logic [7:0] mergeWrite(input logic [7:0] old, input sas_pkg::sas_cpu_req_t req);
    logic [7:0] v;
    begin
      v = old;
      if (req.bitOp) begin
        v[req.bitSel] = req.bitVal;
      end else begin
        v = req.wrData;
      end
      mergeWrite = v;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  sas_pkg::sas_mode_t mode_r;
  logic [sas_pkg::CHAN_CODE_W-1:0] chan_r;
  logic modeWr;
  logic chanWr;
  logic anyWr;
  sas_pkg::sas_mode_t modeNxt;
  logic [7:0] chanNxt;

  assign modeWr = cpuReq.wrEn && (cpuReq.addr == sas_pkg::ADDR_CONV_MODE);
  assign chanWr = cpuReq.wrEn && (cpuReq.addr == sas_pkg::ADDR_CHAN_SEL);
  assign anyWr = modeWr | chanWr;
  assign modeNxt = mergeWrite(mode_r, cpuReq);
  assign chanNxt = mergeWrite({5'h00, chan_r}, cpuReq);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= sas_pkg::CONV_MODE_RESET;
    end else if (modeWr) begin
      mode_r <= modeNxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_r <= sas_pkg::CHAN_SEL_RESET[sas_pkg::CHAN_CODE_W-1:0];
    end else if (chanWr) begin
      chan_r <= chanNxt[sas_pkg::CHAN_CODE_W-1:0];
    end
  end

  // Effective settings after this cycle's write
  logic runNow;
  logic hwNow;
  assign runNow = modeWr ? modeNxt.runControlBit : mode_r.runControlBit;
  assign hwNow = modeWr ? modeNxt.triggerSourceBit : mode_r.triggerSourceBit;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic trigPulse;
  logic comp1_r;
  logic comp2_r;

  sas_trig_edge u_trig (
    .clk(clk),
    .nrst(nrst),
    .pinIn(extTrigIn),
    .edgeSel(mode_r.triggerEdge),
    .edgePulse(trigPulse)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp1_r <= 1'b0;
      comp2_r <= 1'b0;
    end else begin
      comp1_r <= compIn;
      comp2_r <= comp1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sas_pkg::sas_state_t state_r;
  logic [sas_pkg::PHASE_W-1:0] phaseCnt_r;
  logic [2:0] slotCnt_r;
  logic [2:0] bitIdx_r;
  logic [RES_W-1:0] sar_r;
  logic [RES_W-1:0] sarFinal;
  logic phaseEnd;
  logic lastBit;
  logic [sas_pkg::PHASE_W-1:0] slotCycles;

  assign slotCycles = slotLen(mode_r.convTime);
  assign phaseEnd = (phaseCnt_r == sas_pkg::PHASE_W'(1));
  assign lastBit = (bitIdx_r == 3'h0);

  always_comb begin
    sarFinal = sar_r;
    if (!comp2_r) begin
      sarFinal[bitIdx_r] = 1'b0;
    end
  end

  // Where to go when a conversion must (re)start now
  function automatic sas_pkg::sas_state_t startState(input logic run, input logic hw);
    begin
      if (!run) begin
        startState = sas_pkg::ST_IDLE;
      end else if (hw) begin
        startState = sas_pkg::ST_WAIT_TRIG;
      end else begin
        startState = sas_pkg::ST_SAMPLE;
      end
    end
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= sas_pkg::ST_IDLE;
    end else if (anyWr) begin
      // Any register write reinitialises; run bit decides restart
      state_r <= startState(runNow, hwNow);
    end else begin
      unique case (state_r)
        sas_pkg::ST_IDLE: begin
          state_r <= sas_pkg::ST_IDLE;
        end
        sas_pkg::ST_WAIT_TRIG: begin
          if (trigPulse) begin
            state_r <= sas_pkg::ST_SAMPLE;
          end
        end
        sas_pkg::ST_SAMPLE: begin
          if (phaseEnd && slotCnt_r == 3'h0) begin
            state_r <= sas_pkg::ST_CONVERT;
          end
        end
        sas_pkg::ST_CONVERT: begin
          // Trigger pulses are not looked at in this state
          if (phaseEnd && lastBit) begin
            state_r <= startState(mode_r.runControlBit, mode_r.triggerSourceBit);
          end
        end
      endcase
    end
  end

  // Phase timing: sampling spans SAMPLE_SLOTS slots, each bit one slot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phaseCnt_r <= sas_pkg::PHASE_W'(1);
      slotCnt_r <= 3'h0;
    end else if (anyWr || state_r == sas_pkg::ST_IDLE || state_r == sas_pkg::ST_WAIT_TRIG) begin
      phaseCnt_r <= slotLen(anyWr ? modeNxt.convTime : mode_r.convTime);
      slotCnt_r <= 3'(sas_pkg::SAMPLE_SLOTS - 1);
    end else if (phaseEnd) begin
      phaseCnt_r <= slotCycles;
      if (state_r == sas_pkg::ST_CONVERT && lastBit) begin
        // Back-to-back repeat needs the full sampling span again
        slotCnt_r <= 3'(sas_pkg::SAMPLE_SLOTS - 1);
      end else if (slotCnt_r != 3'h0) begin
        slotCnt_r <= slotCnt_r - 3'h1;
      end
    end else begin
      phaseCnt_r <= phaseCnt_r - sas_pkg::PHASE_W'(1);
    end
  end

  // Approximation register and trial bit index
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sar_r <= '0;
      bitIdx_r <= 3'h7;
    end else if (anyWr) begin
      sar_r <= '0;
      bitIdx_r <= 3'h7;
    end else if (state_r == sas_pkg::ST_SAMPLE && phaseEnd && slotCnt_r == 3'h0) begin
      sar_r <= RES_W'(8'h80);
      bitIdx_r <= 3'h7;
    end else if (state_r == sas_pkg::ST_CONVERT && phaseEnd) begin
      if (lastBit) begin
        sar_r <= '0;
        bitIdx_r <= 3'h7;
      end else begin
        // Decided bits steer the next tap through the trial code
        sar_r <= sarFinal | (RES_W'(1) << (bitIdx_r - 3'h1));
        bitIdx_r <= bitIdx_r - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result, done request and first-result flag
  // ----------------------------------------------------------------
  logic [RES_W-1:0] result_r;
  logic resultWr;
  logic pendUndef_r;

  assign resultWr = (state_r == sas_pkg::ST_CONVERT) && phaseEnd && lastBit && !anyWr;

  // No reset: contents are undefined after reset
  always_ff @(posedge clk) begin
    if (resultWr) begin
      result_r <= sarFinal;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convDoneReq <= 1'b0;
    end else begin
      convDoneReq <= resultWr;
    end
  end

  // Run enabled from stop while reference off: first result is suspect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendUndef_r <= 1'b0;
      resultUndef <= 1'b0;
    end else begin
      if (modeWr && modeNxt.runControlBit && !mode_r.runControlBit && !mode_r.referenceEnableBit) begin
        pendUndef_r <= 1'b1;
      end else if (resultWr) begin
        pendUndef_r <= 1'b0;
      end
      if (resultWr) begin
        resultUndef <= pendUndef_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read samples result_r before a same-edge write lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (cpuReq.rdEn) begin
      unique case (cpuReq.addr)
        sas_pkg::ADDR_CONV_MODE: rdData <= mode_r;
        sas_pkg::ADDR_CHAN_SEL: rdData <= {5'h00, chan_r};
        sas_pkg::ADDR_CONV_RESULT: rdData <= 8'(result_r);
        default: rdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Analog-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tapCode <= '0;
      chanSel <= '0;
      sampleEn <= 1'b0;
      refOn <= 1'b0;
    end else begin
      tapCode <= sar_r;
      chanSel <= chan_r;
      sampleEn <= (state_r == sas_pkg::ST_SAMPLE) && !anyWr;
      refOn <= mode_r.referenceEnableBit | mode_r.runControlBit;
    end
  end

endmodule

// *** verification/sas_comp_model.sv ***
// Purpose: Comparator and sample-hold model for the analog side
// Assumes: Channel levels are given as 8-bit codes by the bench
// Notes:   Held level moves only while sampling is enabled
`timescale 1ns/1ps
module sas_comp_model (
  input wire logic clk,
  input wire logic sampleEn,
  input wire logic [2:0] chanSel,
  input wire logic [7:0] tapCode,
  input wire logic [7:0][7:0] chanVal,
  output logic compIn
);
  // ------------
  // Sample and compare
  // ------------
  logic [7:0] held = 8'h00;
  always @(posedge clk) begin
    if (sampleEn === 1'b1) held <= chanVal[chanSel];
  end
  assign compIn = held >= tapCode;
endmodule

// *** verification/sas_core_asserts.sv ***
// Purpose: Port-level checks on the conversion sequencer
// Assumes: One clock; mode and channel mirrored from byte and bit writes
// Notes:   Length windows allow one cycle of output register lag
`timescale 1ns/1ps
module sas_core_asserts #(
  parameter int RES_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire sas_pkg::sas_cpu_req_t cpuReq,
  input wire logic extTrigIn,
  input wire logic [RES_W-1:0] tapCode,
  input wire logic [sas_pkg::CHAN_CODE_W-1:0] chanSel,
  input wire logic sampleEn,
  input wire logic refOn,
  input wire logic convDoneReq
);
  // ------------
  // Mirrors and counters
  // ------------
  logic [7:0] mode_r;
  logic [2:0] chan_r;
  logic sampPrev_r;
  logic trigPrev_r;
  logic [15:0] convCnt_r;
  logic [7:0] trigAge_r;
  wire wrMode = cpuReq.wrEn && cpuReq.addr == sas_pkg::ADDR_CONV_MODE;
  wire wrChan = cpuReq.wrEn && cpuReq.addr == sas_pkg::ADDR_CHAN_SEL;
  wire wrReg = wrMode || wrChan;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mode_r <= 8'h00;
    else if (wrMode && cpuReq.bitOp) mode_r[cpuReq.bitSel] <= cpuReq.bitVal;
    else if (wrMode) mode_r <= cpuReq.wrData;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) chan_r <= 3'h0;
    else if (wrChan && !cpuReq.bitOp) chan_r <= cpuReq.wrData[2:0];
    else if (wrChan && cpuReq.bitSel < 3'h3) chan_r[cpuReq.bitSel[1:0]] <= cpuReq.bitVal;
  end
  // Counts restart on each new sampling phase and each pin change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sampPrev_r <= 1'b0;
      trigPrev_r <= 1'b0;
      convCnt_r <= 16'h0000;
      trigAge_r <= 8'h00;
    end else begin
      sampPrev_r <= sampleEn;
      trigPrev_r <= extTrigIn;
      convCnt_r <= (sampleEn && !sampPrev_r) ? 16'h0001 : convCnt_r + 16'h0001;
      trigAge_r <= (extTrigIn != trigPrev_r) ? 8'h00 : (trigAge_r == 8'hff ? 8'hff : trigAge_r + 8'h01);
    end
  end
  function automatic int convLen(input logic [2:0] code);
    case (code)
      3'h1: return 120;
      3'h2: return 96;
      3'h4: return 288;
      3'h5: return 240;
      3'h6: return 192;
      default: return 144;
    endcase
  endfunction
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Sampling ended on its own, not by a register write
  sequence natFall;
    $fell(sampleEn) && !$past(wrReg) && !$past(wrReg, 2);
  endsequence
  done_len_a: assert property (convDoneReq |-> convCnt_r + 2 >= convLen(mode_r[5:3])
    && convCnt_r <= convLen(mode_r[5:3]) + 1) else $error("done pulse off the conversion length");
  samp_len_a: assert property (natFall |-> convCnt_r + 1 >= convLen(mode_r[5:3]) / 3
    && convCnt_r <= convLen(mode_r[5:3]) / 3 + 1) else $error("sampling phase has wrong length");
  tap_msb_a: assert property (natFall |-> ##[0:2] tapCode == {1'b1, {(RES_W-1){1'b0}}})
    else $error("first trial code is not the top bit");
  done_pulse_a: assert property (convDoneReq |=> !convDoneReq)
    else $error("done request longer than one cycle");
  stop_quiet_a: assert property (wrMode && !cpuReq.bitOp && !cpuReq.wrData[7] |=> !convDoneReq [*8])
    else $error("done request after a stop write");
  idle_quiet_a: assert property (!mode_r[7] && !$past(mode_r[7]) |-> !sampleEn && !convDoneReq)
    else $error("activity while run bit is clear");
  hw_trig_a: assert property ($rose(sampleEn) && mode_r[6] |-> trigAge_r < 8'd10)
    else $error("hardware start without a pin edge");
  ref_on_a: assert property ($stable(mode_r) |-> refOn == (mode_r[7] || mode_r[0]))
    else $error("reference enable does not follow mode");
  chan_sel_a: assert property ($stable(chan_r) |-> chanSel == chan_r)
    else $error("channel output does not follow register");
  cover property (convDoneReq && mode_r[6]);
  cover property (wrReg && !sampleEn && mode_r[7]);
  cover property (wrMode && !cpuReq.wrData[7] && sampleEn);
endmodule
bind sas_core sas_core_asserts #(.RES_W(RES_W)) sas_core_asserts_inst (.clk, .nrst, .cpuReq, .extTrigIn,
  .tapCode, .chanSel, .sampleEn, .refOn, .convDoneReq);

// *** verification/sar_adc_sequencer_tb.sv ***
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Comparator model on the analog side; trigger pin driven here
// Notes:   Inputs move on the falling edge; windows allow register lag
`timescale 1ns/1ps
`define CHK(gv, ev) begin \
  nTests++; \
  if ((gv) !== (ev)) begin \
    errCount++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (gv), (ev)); \
  end \
end
module sar_adc_sequencer_tb;
  logic clk;
  logic nrst;
  sas_pkg::sas_cpu_req_t cpuReq;
  logic [7:0] rdData;
  logic compIn;
  logic extTrigIn;
  logic [7:0] tapCode;
  logic [2:0] chanSel;
  logic sampleEn;
  logic refOn;
  logic convDoneReq;
  logic resultUndef;
  logic [7:0][7:0] chanVal;
  logic [7:0] rdv;
  logic [7:0] expVal;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int lens [6] = '{144, 120, 96, 288, 240, 192};
  int errCount = 0;
  int nTests = 0;
  int cyc = 0;
  int doneCnt = 0;
  int d0;
  int n;
  sas_core #(.RES_W(8)) sas_core_inst (.clk, .nrst, .cpuReq, .rdData, .compIn, .extTrigIn, .tapCode,
    .chanSel, .sampleEn, .refOn, .convDoneReq, .resultUndef);
  sas_comp_model sas_comp_model_inst (.clk, .sampleEn, .chanSel, .tapCode, .chanVal, .compIn);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (convDoneReq === 1'b1) doneCnt++;
    if (cyc == 20000) begin
      errCount++;
      $display("mismatch at %0t: run too long", $time);
      final_report;
    end
  end
  // ------------
  // Register access
  // ------------
  task automatic acc(input logic [15:0] a, input logic w, input logic b, input logic [2:0] s,
    input logic [7:0] d);
    @(negedge clk);
    cpuReq = '{addr: a, wrEn: w, bitOp: b, bitSel: s, bitVal: d[0], wrData: d, rdEn: !w};
    @(posedge clk);
    @(negedge clk);
    cpuReq = '0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(a, 1'b1, 1'b0, 3'h0, d);
  endtask
  task automatic rd(input logic [15:0] a);
    acc(a, 1'b0, 1'b0, 3'h0, 8'h00);
    @(negedge clk);
    rdv = rdData;
  endtask
  task automatic waitDone(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (convDoneReq !== 1'b1 && cnt < 4000);
    if (cnt >= 4000) begin
      errCount++;
      $display("mismatch at %0t: no done request", $time);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ------------
  // Scenarios
  // ------------
  initial begin
    cpuReq = '0;
    nrst = 1'b0;
    extTrigIn = 1'b1;
    chanVal = 64'hc4_33_7e_80_a5_01_5a_ff;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rd(sas_pkg::ADDR_CONV_MODE);
    `CHK(rdv, 8'h00);
    rd(sas_pkg::ADDR_CHAN_SEL);
    `CHK(rdv, 8'h00);
    rd(16'hff83);
    `CHK(rdv, 8'h00);
    wr(sas_pkg::ADDR_CHAN_SEL, 8'hff);
    rd(sas_pkg::ADDR_CHAN_SEL);
    `CHK(rdv, 8'h07);
    `CHK(chanSel, 3'h7);
    acc(sas_pkg::ADDR_CONV_MODE, 1'b1, 1'b1, 3'h0, 8'h01);
    rd(sas_pkg::ADDR_CONV_MODE);
    `CHK(rdv, 8'h01);
    `CHK(refOn, 1'b1);
    // Every time code, software start, back-to-back repeat, hold
    foreach (codes[i]) begin
      wr(sas_pkg::ADDR_CHAN_SEL, 8'(i));
      wr(sas_pkg::ADDR_CONV_MODE, {2'b10, codes[i], 3'b001});
      waitDone(n);
      `CHK(n inside {[lens[i] - 2:lens[i] + 3]}, 1'b1);
      `CHK(resultUndef, 1'b0);
      expVal = ~chanVal[i];
      chanVal[i] = expVal;
      repeat (lens[i] / 2) @(negedge clk);
      chanVal[i] = 8'h3c;
      waitDone(n);
      `CHK(n + lens[i] / 2 inside {[lens[i] - 2:lens[i] + 3]}, 1'b1);
      wr(sas_pkg::ADDR_CONV_MODE, 8'h01);
      rd(sas_pkg::ADDR_CONV_RESULT);
      `CHK(rdv, expVal);
    end
    // Start with the reference off: first result flagged, the next one unflagged
    wr(sas_pkg::ADDR_CONV_MODE, 8'h00);
    wr(sas_pkg::ADDR_CHAN_SEL, 8'h06);
    wr(sas_pkg::ADDR_CONV_MODE, 8'h80);
    waitDone(n);
    `CHK(resultUndef, 1'b1);
    waitDone(n);
    `CHK(resultUndef, 1'b0);
    repeat (70) @(negedge clk);
    wr(sas_pkg::ADDR_CHAN_SEL, 8'h07);
    waitDone(n);
    `CHK(n inside {[142:147]}, 1'b1);
    rd(sas_pkg::ADDR_CONV_RESULT);
    `CHK(rdv, chanVal[7]);
    repeat (70) @(negedge clk);
    d0 = doneCnt;
    wr(sas_pkg::ADDR_CONV_MODE, 8'h00);
    repeat (300) @(negedge clk);
    `CHK(doneCnt - d0, 0);
    `CHK(sampleEn, 1'b0);
    // Hardware start under each edge code, one conversion per selected edge
    for (int e = 0; e < 4; e++) begin
      wr(sas_pkg::ADDR_CONV_MODE, {2'b11, 3'h2, e[1:0], 1'b1});
      d0 = doneCnt;
      extTrigIn = 1'b0;
      repeat (150) @(negedge clk);
      `CHK(doneCnt - d0, int'(e[0]));
      d0 = doneCnt;
      extTrigIn = 1'b1;
      repeat (150) @(negedge clk);
      `CHK(doneCnt - d0, int'(e[1]));
    end
    // Second edge lands inside a running conversion
    d0 = doneCnt;
    extTrigIn = 1'b0;
    repeat (20) @(negedge clk);
    extTrigIn = 1'b1;
    repeat (150) @(negedge clk);
    `CHK(doneCnt - d0, 1);
    wr(sas_pkg::ADDR_CONV_MODE, 8'h00);
    final_report;
  end
endmodule
